// ===== core/rde_emulator.sv
// Emulator end: message generator with output FIFO
`timescale 1ns/1ps
`include "rde_defines.svh"

module rde_fifo #(
    parameter int WIDTH = 37,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys_in,
    input  wire logic             resetn_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic      [WIDTH-1:0] out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    import rde_pkg::*;
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    wire              full  = (wr_q[AW] != rd_q[AW]) &&
                              (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire              empty = (wr_q == rd_q);
    wire              push  = ce_in && in_valid_in && !full;
    wire              pop   = ce_in && out_ready_in && !empty;

    assign in_ready_out  = !full;
    assign out_valid_out = !empty;
    assign out_data_out  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end
endmodule // rde_fifo

module rde_emulator (
    input  wire logic                         clk_sys_in,
    input  wire logic                         resetn_in,
    input  wire logic                         ce_in,
    rde_link_if.emu                           link,
    input  wire logic                         emulator_run_control_in,
    input  wire logic [`RDE_LEN_W-1:0]        trigger_quota_in,
    input  wire logic                         trigger_source_select_in,
    input  wire logic                         event_count_clear_in,
    input  wire logic                         flow_pause_enable_in,
    input  wire logic                         random_size_select_in,
    input  wire logic [`RDE_LEN_W-1:0]        fixed_payload_length_in,
    input  wire logic                         main_clock_source_select_in,
    input  wire logic                         dist_wr_en_in,
    input  wire logic [`RDE_DIST_AW-1:0]      dist_wr_addr_in,
    input  wire logic [`RDE_LEN_W-1:0]        dist_wr_data_in,
    output logic                              main_clock_select_out,
    output logic [`RDE_CARD_CHANNELS-1:0]     channel_enable_out,
    output logic                              running_out,
    output logic [`RDE_WORD_W-1:0]            event_identifier_out,
    output logic [`RDE_LEN_W-1:0]             triggers_sent_out
);
    import rde_pkg::*;

    rde_state_t               state_q;
    logic                     run_d1_q;
    logic [`RDE_LEN_W-1:0]    quota_q;
    logic                     mode_q;
    logic                     flow_q;
    logic                     rand_q;
    logic [`RDE_LEN_W-1:0]    fixlen_q;
    logic                     clksel_q;
    logic [`RDE_PEND_W-1:0]   pend_q;
    logic [`RDE_LEN_W-1:0]    sent_q;
    logic [`RDE_WORD_W-1:0]   evid_q;
    logic [`RDE_LEN_W-1:0]    len_q;
    logic [`RDE_LEN_W-1:0]    rem_q;
    logic [`RDE_BYTE_W-1:0]   byte_q;
    logic [15:0]              lfsr_q;
    logic [`RDE_LEN_W-1:0]    dist_mem [`RDE_DIST_DEPTH];
    rde_word_t                gen_word;
    rde_word_t                fifo_word;
    logic                     gen_ready;

    wire run_rise   = emulator_run_control_in && !run_d1_q;
    wire accept     = link.timing_path[`RDE_ACCEPT_BIT];
    wire quota_done = (quota_q != `RDE_QUOTA_UNLIMITED) &&
                      (sent_q == quota_q);
    wire paused     = flow_q && (|link.pause_path);
    wire trig_ok    = mode_q ? (pend_q != '0) : 1'b1;
    wire can_start  = (state_q == RDE_ARM) && emulator_run_control_in &&
                      !quota_done && !paused && trig_ok;
    wire take       = ce_in && can_start && mode_q;
    wire count_acc  = accept && mode_q && (state_q != RDE_IDLE) &&
                      (pend_q != '1);
    wire gen_valid  = (state_q == RDE_HEAD) || (state_q == RDE_BODY);
    wire step       = ce_in && gen_valid && gen_ready;
    wire body_end   = (rem_q <= `RDE_BYTES_PER_WORD);
    wire [15:0] lfsr_next = lfsr_q[0] ? ((lfsr_q >> 1) ^ `RDE_LFSR_TAPS)
                                      : (lfsr_q >> 1);
    wire [`RDE_LEN_W-1:0] pick_len =
        rand_q ? dist_mem[lfsr_q[`RDE_DIST_AW-1:0]] : fixlen_q;
    wire [`RDE_KEEP_W-1:0] tail_keep =
        (rem_q[1:0] == 2'h1) ? `RDE_KEEP_1 :
        (rem_q[1:0] == 2'h2) ? `RDE_KEEP_2 :
        (rem_q[1:0] == 2'h3) ? `RDE_KEEP_3 : `RDE_KEEP_ALL;
    // Lane 0 carries the earliest byte of each word
    wire [`RDE_WORD_W-1:0] body_data = {byte_q + 8'h03, byte_q + 8'h02,
                                        byte_q + 8'h01, byte_q};

    assign gen_word.data = (state_q == RDE_HEAD) ? evid_q : body_data;
    assign gen_word.keep = (state_q == RDE_HEAD || !body_end) ?
                           `RDE_KEEP_ALL : tail_keep;
    assign gen_word.last = (state_q == RDE_HEAD) ? (len_q == '0) : body_end;

    // One word per cycle: 4 kB every 1250 cycles still leaves headroom
    rde_fifo #(
        .WIDTH ($bits(rde_word_t)),
        .DEPTH (`RDE_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_in    (clk_sys_in),
        .resetn_in     (resetn_in),
        .ce_in         (ce_in),
        .in_data_in    (gen_word),
        .in_valid_in   (gen_valid),
        .in_ready_out  (gen_ready),
        .out_data_out  (fifo_word),
        .out_valid_out (link.valid),
        .out_ready_in  (link.ready)
    );

    assign link.data = fifo_word.data;
    assign link.keep = fifo_word.keep;
    assign link.last = fifo_word.last;

    assign main_clock_select_out = clksel_q;
    assign channel_enable_out    = {{(`RDE_CARD_CHANNELS -
                                      `RDE_ACTIVE_CHANNELS){1'b0}},
                                    {`RDE_ACTIVE_CHANNELS{1'b1}}};
    assign running_out           = (state_q != RDE_IDLE);
    assign event_identifier_out  = evid_q;
    assign triggers_sent_out     = sent_q;

    always_ff @(posedge clk_sys_in) begin
        if (dist_wr_en_in && ce_in) begin
            dist_mem[dist_wr_addr_in] <= dist_wr_data_in;
        end
    end

    // Settings are sampled only at the start edge so a live change
    // cannot corrupt a message in flight
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            run_d1_q <= 1'b0;
            quota_q  <= '0;
            mode_q   <= 1'b0;
            flow_q   <= 1'b0;
            rand_q   <= 1'b0;
            fixlen_q <= '0;
            clksel_q <= `RDE_CLK_TIMING;
            lfsr_q   <= `RDE_LFSR_SEED;
        end else if (ce_in) begin
            run_d1_q <= emulator_run_control_in;
            lfsr_q   <= lfsr_next;
            if (run_rise) begin
                quota_q  <= trigger_quota_in;
                mode_q   <= trigger_source_select_in;
                flow_q   <= flow_pause_enable_in;
                rand_q   <= random_size_select_in;
                fixlen_q <= fixed_payload_length_in;
                clksel_q <= main_clock_source_select_in;
            end
        end
    end

    // Pending accepts: an arrival in the cycle of a take is kept
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            pend_q <= '0;
        end else if (ce_in) begin
            if (run_rise) begin
                pend_q <= '0;
            end else begin
                pend_q <= pend_q + `RDE_PEND_W'(count_acc)
                                 - `RDE_PEND_W'(take);
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            evid_q <= '0;
        end else if (ce_in) begin
            if (event_count_clear_in) begin
                evid_q <= '0;
            end else if (step && state_q == RDE_HEAD) begin
                evid_q <= evid_q + 32'h00000001;
            end
        end
    end

    // A stop request lets the message in flight finish, so the card
    // never sees a frame without its last word
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            state_q <= RDE_IDLE;
            sent_q  <= '0;
            len_q   <= '0;
            rem_q   <= '0;
            byte_q  <= '0;
        end else if (ce_in) begin
            case (state_q)
                RDE_IDLE: begin
                    if (run_rise) begin
                        sent_q  <= '0;
                        state_q <= RDE_ARM;
                    end
                end
                RDE_ARM: begin
                    if (!emulator_run_control_in) begin
                        state_q <= RDE_IDLE;
                    end else if (can_start) begin
                        len_q   <= pick_len;
                        state_q <= RDE_HEAD;
                    end
                end
                RDE_HEAD: begin
                    if (gen_ready) begin
                        sent_q <= sent_q + 16'h0001;
                        rem_q  <= len_q;
                        byte_q <= '0;
                        state_q <= (len_q == '0) ? RDE_ARM : RDE_BODY;
                    end
                end
                RDE_BODY: begin
                    if (gen_ready) begin
                        byte_q <= byte_q + 8'h04;
                        rem_q  <= rem_q - `RDE_BYTES_PER_WORD;
                        if (body_end) begin
                            state_q <= RDE_ARM;
                        end
                    end
                end
                default: state_q <= RDE_IDLE;
            endcase
        end
    end
endmodule // rde_emulator

// ===== core/rde_defines.svh
// Constants shared by both ends of the readout data emulator link
// Behaviour
// - Emit continuously or once per accept
// - Settings apply on run-control rising edge
// - Trigger quota limits count; all-ones unlimited
// - Source select one follows accepts, zero self
// - Message is identifier then incrementing bytes
// - Random select zero uses fixed length
// - Random lengths drawn from loaded table
// - Flow pause support enabled by enable bit
// - Clock select zero timing, one local
// - Card forwards every accept in triggered mode
// - Pause carried on 2-bit path
// - Timing information carried on 8-bit path
// - Drive only 24 of 48 channels
// - Sustain multi-kilobyte messages at 100 kHz
`ifndef RDE_DEFINES_SVH
`define RDE_DEFINES_SVH

`define RDE_WORD_W          32
`define RDE_KEEP_W          4
`define RDE_LEN_W           16
`define RDE_BYTE_W          8
`define RDE_PEND_W          8
`define RDE_QUOTA_UNLIMITED 16'hFFFF
`define RDE_FIFO_DEPTH      16
`define RDE_DIST_AW         8
`define RDE_DIST_DEPTH      256
`define RDE_LFSR_SEED       16'hACE1
`define RDE_LFSR_TAPS       16'hB400
`define RDE_PAUSE_W         2
`define RDE_TIMING_W        8
`define RDE_ACCEPT_BIT      0
`define RDE_CARD_CHANNELS   48
`define RDE_ACTIVE_CHANNELS 24
`define RDE_CLK_TIMING      1'b0
`define RDE_CLK_LOCAL       1'b1
`define RDE_KEEP_ALL        4'hF
`define RDE_KEEP_1          4'h1
`define RDE_KEEP_2          4'h3
`define RDE_KEEP_3          4'h7
`define RDE_BYTES_PER_WORD  16'h0004

`endif

// ===== core/rde_pkg.sv
// Types shared by both ends of the readout data emulator link
package rde_pkg;
    typedef enum logic [1:0] {
        RDE_IDLE = 2'b00,
        RDE_ARM  = 2'b01,
        RDE_HEAD = 2'b11,
        RDE_BODY = 2'b10
    } rde_state_t;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  keep;
        logic        last;
    } rde_word_t;
endpackage

// ===== core/rde_link_if.sv
// Link between the emulator and the readout card
`timescale 1ns/1ps
`include "rde_defines.svh"
interface rde_link_if;
    logic [`RDE_WORD_W-1:0]   data;
    logic [`RDE_KEEP_W-1:0]   keep;
    logic                     last;
    logic                     valid;
    logic                     ready;
    logic [`RDE_PAUSE_W-1:0]  pause_path;
    logic [`RDE_TIMING_W-1:0] timing_path;

    modport emu  (output data, keep, last, valid,
                  input  ready, pause_path, timing_path);
    modport card (input  data, keep, last, valid,
                  output ready, pause_path, timing_path);
endinterface

// ===== core/rde_card.sv
// Readout card end: accept forwarding, pause signalling, stream sink
`timescale 1ns/1ps
`include "rde_defines.svh"

module rde_card (
    input  wire logic                     clk_sys_in,
    input  wire logic                     resetn_in,
    input  wire logic                     ce_in,
    rde_link_if.card                      link,
    input  wire logic                     accept_in,
    input  wire logic                     host_pause_enable_in,
    input  wire logic                     pause_request_in,
    output logic [`RDE_WORD_W-1:0]        data_out,
    output logic [`RDE_KEEP_W-1:0]        keep_out,
    output logic                          last_out,
    output logic                          valid_out,
    input  wire logic                     ready_in,
    output logic [`RDE_LEN_W-1:0]         messages_out
);
    import rde_pkg::*;

    logic [`RDE_TIMING_W-1:0] timing_q;
    logic [`RDE_PAUSE_W-1:0]  pause_q;
    logic [`RDE_WORD_W-1:0]   data_q;
    logic [`RDE_KEEP_W-1:0]   keep_q;
    logic                     last_q;
    logic                     valid_q;
    logic [`RDE_LEN_W-1:0]    msg_q;

    wire accept_word = !valid_q || ready_in;
    wire take_word   = ce_in && link.valid && accept_word;
    wire [`RDE_TIMING_W-1:0] timing_d =
        {{(`RDE_TIMING_W-1){1'b0}}, accept_in} << `RDE_ACCEPT_BIT;

    assign link.ready       = ce_in && accept_word;
    assign link.timing_path = timing_q;
    assign link.pause_path  = pause_q;
    assign data_out         = data_q;
    assign keep_out         = keep_q;
    assign last_out         = last_q;
    assign valid_out        = valid_q;
    assign messages_out     = msg_q;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            timing_q <= '0;
            pause_q  <= '0;
        end else if (ce_in) begin
            timing_q <= timing_d;
            pause_q  <= {`RDE_PAUSE_W{host_pause_enable_in &&
                                      pause_request_in}};
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            data_q  <= '0;
            keep_q  <= '0;
            last_q  <= 1'b0;
            valid_q <= 1'b0;
            msg_q   <= '0;
        end else if (ce_in) begin
            if (take_word) begin
                data_q  <= link.data;
                keep_q  <= link.keep;
                last_q  <= link.last;
                valid_q <= 1'b1;
                msg_q   <= msg_q + `RDE_LEN_W'(link.last);
            end else if (ready_in) begin
                valid_q <= 1'b0;
            end
        end
    end
endmodule // rde_card

// ===== tb/rde_link_sva.sv
// Assertions on the link that joins the emulator and the card
`timescale 1ns/1ps
module rde_link_sva (
    input wire logic        clk_sys_in,
    input wire logic        resetn_in,
    input wire logic [31:0] data,
    input wire logic [3:0]  keep,
    input wire logic        last,
    input wire logic        valid,
    input wire logic        ready,
    input wire logic [1:0]  pause_path,
    input wire logic [7:0]  timing_path
);
    logic       hdr_q;
    logic [7:0] byte_q;
    wire        take = valid & ready;
    wire [31:0] mask = {{8{keep[3]}},{8{keep[2]}},{8{keep[1]}},{8{keep[0]}}};
    wire [31:0] want = {byte_q + 8'h03, byte_q + 8'h02,
                        byte_q + 8'h01, byte_q};

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    // Byte count restarts at each header, so every message counts from 0
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            hdr_q  <= 1'b1;
            byte_q <= 8'h00;
        end else if (take) begin
            hdr_q  <= last;
            byte_q <= hdr_q ? 8'h00 : byte_q + 8'h04;
        end
    end

    property p_hold;
        valid && !ready |=> valid && $stable({data, keep, last});
    endproperty
    a_hold: assert property (p_hold)
        else $error("stalled word changed");
    property p_full;
        valid && !last |-> keep == 4'hF;
    endproperty
    a_full: assert property (p_full)
        else $error("partial keep before last");
    property p_tail;
        valid && last |-> keep inside {4'h1, 4'h3, 4'h7, 4'hF};
    endproperty
    a_tail: assert property (p_tail)
        else $error("tail keep not packed low");
    property p_bytes;
        take && !hdr_q |-> (data & mask) == (want & mask);
    endproperty
    a_bytes: assert property (p_bytes)
        else $error("payload bytes out of sequence");
    property p_gapless;
        take && !last |-> ##[1:8] valid;
    endproperty
    a_gapless: assert property (p_gapless)
        else $error("message stalled mid-flight");
    property p_pause;
        pause_path == 2'h0 || pause_path == 2'h3;
    endproperty
    a_pause: assert property (p_pause)
        else $error("pause bits disagree");
    property p_timing;
        timing_path[7:1] == 7'h00;
    endproperty
    a_timing: assert property (p_timing)
        else $error("unused timing bits set");
    property p_reset;
        $rose(resetn_in) |-> !valid && pause_path == 2'h0 && !timing_path[0];
    endproperty
    a_reset: assert property (p_reset)
        else $error("link busy after reset");

    c_empty: cover property (valid && hdr_q && last);
    c_stall: cover property (valid && !ready);
    c_pause: cover property (pause_path == 2'h3);
endmodule // rde_link_sva

// ===== tb/test_readout_data_emulator.sv
// Bench joining emulator and card, checking messages end to end
`timescale 1ns/1ps
module test_readout_data_emulator;
    logic        clk_sys_in, resetn_in, run, mode, flow, rnd, csel, clr;
    logic        dwe, acc, hpe, preq, rdy, lout, vout, csel_o, runo, in_msg;
    logic        ce, ce_rand;
    logic [15:0] quota, flen, dwd, msgs, sent, len;
    logic [7:0]  dwa;
    logic [3:0]  kout;
    logic [31:0] dout, idout, exp_id;
    logic [47:0] chen;
    int          seed = 94466;
    int          miscompares, checked, cycles, nmsg, blen, exp_len, n, total;
    localparam logic [15:0] DIST_LEN = 16'h000B;

    rde_link_if link ();
    rde_emulator rde_emulator_inst (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .ce_in(ce),
        .link(link), .emulator_run_control_in(run),
        .trigger_quota_in(quota), .trigger_source_select_in(mode),
        .event_count_clear_in(clr), .flow_pause_enable_in(flow),
        .random_size_select_in(rnd), .fixed_payload_length_in(flen),
        .main_clock_source_select_in(csel), .dist_wr_en_in(dwe),
        .dist_wr_addr_in(dwa), .dist_wr_data_in(dwd),
        .main_clock_select_out(csel_o), .channel_enable_out(chen),
        .running_out(runo), .event_identifier_out(idout),
        .triggers_sent_out(sent));
    rde_card rde_card_inst (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .ce_in(ce),
        .link(link), .accept_in(acc), .host_pause_enable_in(hpe),
        .pause_request_in(preq), .data_out(dout), .keep_out(kout),
        .last_out(lout), .valid_out(vout), .ready_in(rdy),
        .messages_out(msgs));
    rde_link_sva rde_link_sva_inst (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .data(link.data),
        .keep(link.keep), .last(link.last), .valid(link.valid),
        .ready(link.ready), .pause_path(link.pause_path),
        .timing_path(link.timing_path));

    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    // Random ready keeps the card's output stage stalling
    // Enable gaps only where no accept pulse could be frozen out
    always @(posedge clk_sys_in) begin
        rdy <= ($random(seed) & 3) != 0;
        ce  <= !ce_rand || (($random(seed) & 7) != 0);
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    // Rebuild each message from the card's output stage
    always @(posedge clk_sys_in) begin
        if (resetn_in && ce && vout && rdy) begin
            if (!in_msg) begin
                check(48'(dout), 48'(exp_id));
                exp_id = exp_id + 32'h1;
                blen = 0;
            end else begin
                for (int k = 0; k < 4; k++) begin
                    if (kout[k]) begin
                        check(48'(dout[8*k+:8]), 48'(blen[7:0]));
                        blen++;
                    end
                end
            end
            if (lout) begin
                check(48'(blen), 48'(exp_len));
                nmsg++;
                total++;
            end
            in_msg = !lout;
        end
    end

    task automatic check(input logic [47:0] seen, input logic [47:0] want);
        checked++;
        if (seen !== want) begin
            miscompares++;
            $display("FAIL %0t: saw %0h expected %0h", $time, seen, want);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge clk_sys_in);
    endtask

    task automatic settle();
        run <= 1'b0;
        cyc(2);
        for (int i = 0; i < 400 && (runo || link.valid || vout); i++) begin
            cyc(1);
        end
        check(48'(idout), 48'(exp_id));
        check(48'(msgs), 48'(total));
        check(48'(runo), 48'h0);
    endtask

    // Random runs draw from a table loaded with one length everywhere
    function automatic int want_len(input logic r, input logic [15:0] l);
        return r ? int'(DIST_LEN) : int'(l);
    endfunction

    task automatic start(input logic [15:0] q, input logic m, input logic f,
                         input logic r, input logic [15:0] l, input logic c);
        settle();
        quota <= q;
        mode <= m;
        flow <= f;
        rnd <= r;
        flen <= l;
        csel <= c;
        nmsg = 0;
        exp_len = want_len(r, l);
        cyc(1);
        run <= 1'b1;
        cyc(2);
        check(48'(csel_o), 48'(c));
        check(48'(runo), 48'h1);
    endtask

    task automatic wait_msgs(input int c);
        for (int i = 0; i < 3000 && nmsg < c; i++) begin
            cyc(1);
        end
    endtask

    // Some accepts come back to back, others spaced by a cycle
    task automatic accepts(input int c);
        for (int i = 0; i < c; i++) begin
            acc <= 1'b1;
            cyc(1);
            if ($random(seed) & 1) begin
                acc <= 1'b0;
                cyc(1);
            end
        end
        acc <= 1'b0;
        cyc(1);
    endtask

    task automatic give_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        {run, mode, flow, rnd, csel, clr, dwe, acc, hpe, preq} = 10'h000;
        {quota, flen, dwd, dwa} = 56'h0;
        ce_rand = 1'b0;
        in_msg = 1'b0;
        exp_id = 32'h0;
        resetn_in = 1'b0;
        cyc(6);
        resetn_in <= 1'b1;
        check(chen, 48'h000000FFFFFF);
        for (int i = 0; i < 5; i++) begin
            len = (i < 2) ? 16'(4 * i) : 16'($random(seed) & 63);
            start(16'(i + 1), 1'b0, 1'b0, 1'b0, len, i[0]);
            wait_msgs(i + 1);
            cyc(40);
            check(48'(nmsg), 48'(i + 1));
            check(48'(sent), 48'(i + 1));
        end
        settle();
        clr <= 1'b1;
        cyc(2);
        clr <= 1'b0;
        exp_id = 32'h0;
        check(48'(idout), 48'h0);
        // A length change without a run edge must not reach the messages
        start(16'hFFFF, 1'b0, 1'b0, 1'b0, 16'h5, 1'b1);
        flen <= 16'h9;
        ce_rand <= 1'b1;
        wait_msgs(20);
        ce_rand <= 1'b0;
        check(48'(nmsg >= 20), 48'h1);
        settle();
        accepts(2);
        start(16'hFFFF, 1'b1, 1'b0, 1'b0, 16'h7, 1'b0);
        n = ($random(seed) & 3) + 3;
        accepts(n);
        cyc(100);
        check(48'(nmsg), 48'(n));
        start(16'hFFFF, 1'b1, 1'b1, 1'b0, 16'h8, 1'b0);
        hpe <= 1'b1;
        preq <= 1'b1;
        cyc(2);
        accepts(3);
        cyc(60);
        check(48'(nmsg), 48'h0);
        preq <= 1'b0;
        cyc(100);
        check(48'(nmsg), 48'h3);
        start(16'hFFFF, 1'b1, 1'b0, 1'b0, 16'h8, 1'b0);
        preq <= 1'b1;
        cyc(2);
        accepts(2);
        cyc(100);
        check(48'(nmsg), 48'h2);
        preq <= 1'b0;
        // Every entry differs from the fixed field, so the source shows
        for (int i = 0; i < 256; i++) begin
            dwe <= 1'b1;
            dwa <= 8'(i);
            dwd <= DIST_LEN;
            cyc(1);
        end
        dwe <= 1'b0;
        start(16'h4, 1'b0, 1'b0, 1'b1, 16'h3, 1'b1);
        wait_msgs(4);
        cyc(40);
        check(48'(nmsg), 48'h4);
        settle();
        give_verdict();
    end
endmodule // test_readout_data_emulator
